//--- ppl_printer_port.sv
// Pin-level logic of the printer parallel port
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Strobe pin is inverse of control bit 0
// - Line-feed pin is inverse of control bit 1
// - Initialize pin follows control bit 2 directly
// - Select-in pin is inverse of control bit 3
// - Error input appears in status bit 3
// - Eight data lines float when port deselected
// - EPP cycles stretched by releasing channel-ready late
module ppl_printer_port
  import ppl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ctrl_wr,
  input wire logic [3:0] ctrl_wdata,
  input wire logic data_wr,
  input wire logic [BYTE_W-1:0] data_wdata,
  input wire logic port_select,
  input wire logic bus_dir_in,
  input wire logic epp_mode,
  input wire logic epp_cyc_req,
  input wire logic busy,
  input wire logic ack_n,
  input wire logic paper_out,
  input wire logic printer_selected,
  input wire logic err_n,
  input wire logic [BYTE_W-1:0] printer_byte_bus_i,
  output logic [BYTE_W-1:0] printer_byte_bus_o,
  output logic printer_byte_bus_oe_n,
  output logic print_strobe_n,
  output logic line_feed_n,
  output logic printer_init_n,
  output logic select_in_n,
  output logic host_cycle_ready_o,
  output logic host_cycle_ready_oe_n,
  output logic [3:0] ctrl_rdata,
  output logic [7:0] status_rdata,
  output logic [BYTE_W-1:0] data_rdata,
  output logic epp_done
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  ppl_pin_in_t pins_async;
  ppl_pin_in_t pins_s;
  logic [BYTE_W-1:0] bus_s;

  assign pins_async = '{busy: busy, ack_n: ack_n, paper_out: paper_out,
                        printer_selected: printer_selected, err_n: err_n};

  ppl_sync #(.WIDTH($bits(ppl_pin_in_t) + BYTE_W)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({pins_async, printer_byte_bus_i}),
    .sync_out({pins_s, bus_s})
  );

  // ****************************************
  // Control register and printer outputs
  // ****************************************
  ppl_ctrl_wr_t cw;
  logic [3:0] ctrl_r, ctrl_nxt;
  logic strobe_n_r, strobe_n_nxt;
  logic feed_n_r, feed_n_nxt;
  logic init_n_r, init_n_nxt;
  logic selin_n_r, selin_n_nxt;

  assign cw = '{wr: ctrl_wr, data: ctrl_wdata};

  always_comb begin
    ctrl_nxt = cw.wr ? cw.data : ctrl_r;
    // Pins derived from the next value so they move with the register
    strobe_n_nxt = ~ctrl_nxt[CTL_STROBE];
    feed_n_nxt = ~ctrl_nxt[CTL_FEED];
    init_n_nxt = ctrl_nxt[CTL_INIT];
    selin_n_nxt = ~ctrl_nxt[CTL_SELIN];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      strobe_n_r <= ~CTRL_RST[CTL_STROBE];
      feed_n_r <= ~CTRL_RST[CTL_FEED];
      init_n_r <= CTRL_RST[CTL_INIT];
      selin_n_r <= ~CTRL_RST[CTL_SELIN];
    end else begin
      ctrl_r <= ctrl_nxt;
      strobe_n_r <= strobe_n_nxt;
      feed_n_r <= feed_n_nxt;
      init_n_r <= init_n_nxt;
      selin_n_r <= selin_n_nxt;
    end
  end

  // ****************************************
  // Data latch and bus drive
  // ****************************************
  logic [BYTE_W-1:0] dout_r, dout_nxt;
  logic [BYTE_W-1:0] din_r, din_nxt;
  logic bus_oe_n_r, bus_oe_n_nxt;

  always_comb begin
    dout_nxt = data_wr ? data_wdata : dout_r;
    din_nxt = bus_s;
    // Released unless selected and driving outward
    bus_oe_n_nxt = ~(port_select & ~bus_dir_in);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dout_r <= DATA_RST;
      din_r <= DATA_RST;
      bus_oe_n_r <= 1'b1;
    end else begin
      dout_r <= dout_nxt;
      din_r <= din_nxt;
      bus_oe_n_r <= bus_oe_n_nxt;
    end
  end

  // ****************************************
  // Status register
  // ****************************************
  logic [7:0] stat_r, stat_nxt;

  always_comb begin
    stat_nxt = STAT_RST;
    stat_nxt[ST_ERR] = pins_s.err_n;
    stat_nxt[ST_SEL] = pins_s.printer_selected;
    stat_nxt[ST_PAPER] = pins_s.paper_out;
    stat_nxt[ST_ACK] = pins_s.ack_n;
    stat_nxt[ST_BUSY] = pins_s.busy;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ****************************************
  // EPP cycle stretching
  // ****************************************
  // Ready is open drain: pulled low (enable active) to hold the host cycle.
  // No timeout: a printer that never answers stalls the host cycle.
  ppl_epp_st_t epp_st_r, epp_st_nxt;
  logic hold_r, hold_nxt;
  logic done_r, done_nxt;

  always_comb begin
    epp_st_nxt = epp_st_r;
    done_nxt = 1'b0;
    case (epp_st_r)
      EPP_IDLE: begin
        if (epp_mode && epp_cyc_req) begin
          epp_st_nxt = EPP_WAIT_ACK;
        end
      end
      EPP_WAIT_ACK: begin
        if (pins_s.busy) begin
          epp_st_nxt = EPP_WAIT_DONE;
        end
      end
      EPP_WAIT_DONE: begin
        if (!pins_s.busy) begin
          epp_st_nxt = EPP_HOLD;
          done_nxt = 1'b1;
        end
      end
      EPP_HOLD: begin
        if (!epp_cyc_req) begin
          epp_st_nxt = EPP_IDLE;
        end
      end
      default: epp_st_nxt = EPP_IDLE;
    endcase
    hold_nxt = (epp_st_nxt == EPP_WAIT_ACK) || (epp_st_nxt == EPP_WAIT_DONE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      epp_st_r <= EPP_IDLE;
      hold_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      epp_st_r <= epp_st_nxt;
      hold_r <= hold_nxt;
      done_r <= done_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign print_strobe_n = strobe_n_r;
  assign line_feed_n = feed_n_r;
  assign printer_init_n = init_n_r;
  assign select_in_n = selin_n_r;
  assign printer_byte_bus_o = dout_r;
  assign printer_byte_bus_oe_n = bus_oe_n_r;
  assign host_cycle_ready_o = 1'b0;
  assign host_cycle_ready_oe_n = ~hold_r;
  assign ctrl_rdata = ctrl_r;
  assign status_rdata = stat_r;
  assign data_rdata = din_r;
  assign epp_done = done_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_STROBE_INV: assert property (ctrl_wr |=> print_strobe_n == !$past(ctrl_wdata[CTL_STROBE]))
    else $error("strobe not inverse of control bit 0");
  AST_FEED_INV: assert property (line_feed_n == !ctrl_rdata[CTL_FEED])
    else $error("line feed not inverse of control bit 1");
  AST_INIT_DIRECT: assert property (ctrl_wr |=> printer_init_n == $past(ctrl_wdata[CTL_INIT]))
    else $error("init not equal to control bit 2");
  AST_SELIN_INV: assert property (select_in_n == !ctrl_rdata[CTL_SELIN])
    else $error("select-in not inverse of control bit 3");
  AST_ERR_STATUS: assert property ($stable(err_n)[*4] |-> status_rdata[ST_ERR] == err_n)
    else $error("error input not in status bit 3");
  AST_BUS_FLOAT: assert property (!port_select |=> printer_byte_bus_oe_n)
    else $error("data bus driven while deselected");
  AST_EPP_HOLD: assert property ((epp_st_r == EPP_IDLE && epp_mode && epp_cyc_req) |=> !host_cycle_ready_oe_n)
    else $error("ready not pulled low at cycle start");
  AST_EPP_RELEASE: assert property (epp_done |-> host_cycle_ready_oe_n ##1 host_cycle_ready_oe_n)
    else $error("ready still held after completion");
  AST_BUSY_STATUS: assert property ($stable(busy)[*4] |-> status_rdata[ST_BUSY] == busy)
    else $error("busy not in status bit 7");
  AST_ACK_STATUS: assert property ($stable(ack_n)[*4] |-> status_rdata[ST_ACK] == ack_n)
    else $error("ack not in status bit 6");

  COV_EPP_DONE: cover property (epp_done);
  COV_STROBE_LOW: cover property (!print_strobe_n ##1 print_strobe_n);
  COV_BUS_DRIVE: cover property (!printer_byte_bus_oe_n);
endmodule

`default_nettype wire

//--- ppl_pkg_sync.sv
// Constants, types and the two-stage input synchroniser for the printer port
`timescale 1ns/1ps
`default_nettype none

package ppl_pkg;
  // ****************************************
  // Control and status layout
  // ****************************************
  localparam int CTL_STROBE = 0;
  localparam int CTL_FEED = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELIN = 3;
  localparam int ST_ERR = 3;
  localparam int ST_SEL = 4;
  localparam int ST_PAPER = 5;
  localparam int ST_ACK = 6;
  localparam int ST_BUSY = 7;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam int SYNC_STAGES = 2;
  localparam int BYTE_W = 8;

  // Printer-driven levels, all asynchronous to mclk
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_out;
    logic printer_selected;
    logic err_n;
  } ppl_pin_in_t;

  // Host-side control write
  typedef struct packed {
    logic wr;
    logic [3:0] data;
  } ppl_ctrl_wr_t;

  typedef enum logic [1:0] {
    EPP_IDLE,
    EPP_WAIT_ACK,
    EPP_WAIT_DONE,
    EPP_HOLD
  } ppl_epp_st_t;
endpackage

module ppl_sync
  import ppl_pkg::*;
#(
  parameter int WIDTH = 13
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // First stage feeds only the second stage
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

`default_nettype wire

//--- ppl_printer_model.sv
// Behavioural line printer facing the port pins
`timescale 1ns/1ps
`default_nettype none

module ppl_printer_model (
  input wire logic mclk,
  input wire logic print_strobe_n,
  input wire logic select_in_n,
  input wire logic no_paper,
  input wire logic fault,
  input wire logic [7:0] printer_byte_bus_o,
  input wire logic printer_byte_bus_oe_n,
  output logic busy,
  output logic ack_n,
  output logic paper_out,
  output logic printer_selected,
  output logic err_n,
  output logic [7:0] printer_byte_bus_i
);
  // ****************************************
  // Pin levels
  // ****************************************
  logic stb_q = 1'b1;
  logic [3:0] cnt = 4'h0;
  assign paper_out = no_paper;
  assign printer_selected = ~select_in_n;
  assign err_n = ~fault;
  // Printer drives its own byte only once the port lets go
  assign printer_byte_bus_i = printer_byte_bus_oe_n ? 8'h3c : printer_byte_bus_o;
  initial begin
    busy = 1'b0;
    ack_n = 1'b1;
  end
  always @(posedge mclk) begin
    stb_q <= print_strobe_n;
    if (stb_q && !print_strobe_n) begin
      busy <= 1'b1;
      cnt <= 4'h8;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      busy <= cnt != 4'h1;
      ack_n <= cnt != 4'h1;
    end else begin
      ack_n <= 1'b1;
    end
  end
endmodule

`default_nettype wire

//--- tb.sv
// Self-checking bench for the printer port pin logic
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ppl_pkg::*;
  // ****************************************
  // Harness
  // ****************************************
  logic mclk = 1'b0, rst_n = 1'b0, ctrl_wr = 1'b0, data_wr = 1'b0, port_select = 1'b0, bus_dir_in = 1'b0;
  logic epp_mode = 1'b0, epp_cyc_req = 1'b0, no_paper = 1'b0, fault = 1'b0;
  logic [3:0] ctrl_wdata = 4'h0, ctrl_rdata, cv;
  logic [7:0] data_wdata = 8'h00, printer_byte_bus_i, printer_byte_bus_o, status_rdata, data_rdata;
  logic busy, ack_n, paper_out, printer_selected, err_n, printer_byte_bus_oe_n, print_strobe_n, line_feed_n;
  logic printer_init_n, select_in_n, host_cycle_ready_o, host_cycle_ready_oe_n, epp_done;
  int err_total = 0, total_checks = 0, n;

  ppl_printer_port ppl_printer_port_i (.mclk, .rst_n, .ctrl_wr, .ctrl_wdata, .data_wr, .data_wdata, .port_select,
    .bus_dir_in, .epp_mode, .epp_cyc_req, .busy, .ack_n, .paper_out, .printer_selected, .err_n,
    .printer_byte_bus_i, .printer_byte_bus_o, .printer_byte_bus_oe_n, .print_strobe_n, .line_feed_n,
    .printer_init_n, .select_in_n, .host_cycle_ready_o, .host_cycle_ready_oe_n, .ctrl_rdata, .status_rdata,
    .data_rdata, .epp_done);
  ppl_printer_model ppl_printer_model_i (.mclk, .print_strobe_n, .select_in_n, .no_paper, .fault,
    .printer_byte_bus_o, .printer_byte_bus_oe_n, .busy, .ack_n, .paper_out, .printer_selected, .err_n,
    .printer_byte_bus_i);

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr_ctl(input logic [3:0] v);
    @(posedge mclk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= v;
    @(posedge mclk);
    ctrl_wr <= 1'b0;
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    stop_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("pins_rst", 8'h0d, {4'h0, print_strobe_n, line_feed_n, printer_init_n, select_in_n});
    for (n = 0; n < 4; n++) begin
      cv = 4'h1 << n;
      wr_ctl(cv);
      chk("pins", {4'h0, ~cv[0], ~cv[1], cv[2], ~cv[3]}, {4'h0, print_strobe_n, line_feed_n, printer_init_n, select_in_n});
      chk("ctrl_rdata", {4'h0, cv}, {4'h0, ctrl_rdata});
    end
    wr_ctl(4'h0);
    wr_ctl(4'h1);
    repeat (5) @(posedge mclk);
    #1;
    chk("st_busy", 8'h01, 8'(status_rdata[ST_BUSY]));
    wr_ctl(4'h8);
    @(posedge mclk);
    no_paper <= 1'b1;
    fault <= 1'b1;
    repeat (14) @(posedge mclk);
    #1;
    chk("status_a", 8'h70, status_rdata);
    wr_ctl(4'h0);
    @(posedge mclk);
    no_paper <= 1'b0;
    fault <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    chk("status_b", 8'h48, status_rdata);
    @(posedge mclk);
    data_wr <= 1'b1;
    data_wdata <= 8'ha5;
    @(posedge mclk);
    data_wr <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(posedge mclk);
      port_select <= n[1];
      bus_dir_in <= n[0];
      repeat (2) @(posedge mclk);
      #1;
      chk("bus_oe_n", {7'h00, ~(n[1] & ~n[0])}, 8'(printer_byte_bus_oe_n));
      if (n == 2) chk("bus_o", 8'ha5, printer_byte_bus_o);
    end
    repeat (4) @(posedge mclk);
    #1;
    chk("data_rdata", 8'h3c, data_rdata);
    @(posedge mclk);
    epp_mode <= 1'b1;
    epp_cyc_req <= 1'b1;
    @(posedge mclk);
    #1;
    chk("rdy_oe_n", 8'h00, 8'(host_cycle_ready_oe_n));
    chk("rdy_o", 8'h00, 8'(host_cycle_ready_o));
    wr_ctl(4'h1);
    n = 0;
    while (epp_done !== 1'b1 && n < 40) begin
      chk("rdy_hold", 8'h00, 8'(host_cycle_ready_oe_n));
      @(posedge mclk);
      #1;
      n++;
    end
    chk("epp_done", 8'h01, 8'(epp_done));
    chk("rdy_free", 8'h01, 8'(host_cycle_ready_oe_n));
    @(posedge mclk);
    epp_cyc_req <= 1'b0;
    repeat (3) @(posedge mclk);
    // Stretching must stay off outside the enhanced mode
    epp_mode <= 1'b0;
    epp_cyc_req <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("rdy_off", 8'h01, 8'(host_cycle_ready_oe_n));
    @(posedge mclk);
    epp_cyc_req <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("pins_rst2", 8'h0d, {4'h0, print_strobe_n, line_feed_n, printer_init_n, select_in_n});
    chk("rdy_rst2", 8'h01, 8'(host_cycle_ready_oe_n));
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("status_c", 8'h48, status_rdata);
    stop_test();
  end
endmodule

`default_nettype wire
